// >>> rtl/itf_symbol_validator.sv
// interleaved 2 of 5 symbol validator with axi4-lite settings registers
// How it works
// - decode only when enabled; off after reset
// - each digit is five elements, two wide
// - bars carry first digit, spaces the second
// - send check digit only when enabled; default off
// - two lengths 0..64, reset 16 and 6
// - odd length writes round down to even
// - exact mode: length equals either setting
// - range mode rejects outside span; on after reset
// - smaller setting is lower bound, larger upper
// - guard option requires guard bars; default off
// - guard bar is at least twice wide bar
module itf_symbol_validator
   import itf_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [itf_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [itf_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic pair_valid,
   input wire logic [4:0] pair_bar_pattern,
   input wire logic [4:0] pair_space_pattern,
   input wire logic pair_last,
   input wire logic [itf_pkg::WIDTH_W-1:0] wide_bar_width,
   input wire logic [itf_pkg::WIDTH_W-1:0] lead_guard_width,
   input wire logic [itf_pkg::WIDTH_W-1:0] trail_guard_width,
   input wire logic check_pass,
   output logic char_valid,
   output logic [itf_pkg::CHAR_W-1:0] char_data,
   output logic char_last,
   output logic symbol_reject
);
   import itf_pkg::*;

   // element pattern (1 = wide) to digit, 0xF when not a legal digit
   function automatic logic [3:0] pattern_to_digit(input logic [4:0] p);
      logic [3:0] d;
      d = 4'hF;
      if ($countones(p) == 2) begin
         case (p)
            5'b00110: d = 4'h0;
            5'b10001: d = 4'h1;
            5'b01001: d = 4'h2;
            5'b11000: d = 4'h3;
            5'b00101: d = 4'h4;
            5'b10100: d = 4'h5;
            5'b01100: d = 4'h6;
            5'b00011: d = 4'h7;
            5'b10010: d = 4'h8;
            5'b01010: d = 4'h9;
            default: d = 4'hF;
         endcase
      end
      return d;
   endfunction

   function automatic logic is_guard(input logic [WIDTH_W-1:0] g, input logic [WIDTH_W-1:0] w);
      return ({1'b0, g} >= {w, 1'b0}) && (w != '0);
   endfunction

   function automatic logic [LEN_W-1:0] even_len(input logic [31:0] v);
      logic [LEN_W-1:0] l;
      l = (v[7:0] > 8'h40) ? LEN_MAX : v[LEN_W-1:0];
      return {l[LEN_W-1:1], 1'b0};
   endfunction

   // register file
   logic [4:0] ctrl_reg;
   logic [LEN_W-1:0] len1_reg;
   logic [LEN_W-1:0] len2_reg;
   logic [15:0] acc_cnt_reg;
   logic [15:0] rej_cnt_reg;
   logic [2:0] last_cause_reg;
   logic [LEN_W-1:0] last_len_reg;

   // axi write channel
   logic aw_held_reg;
   logic w_held_reg;
   logic [ADDR_W-1:0] awaddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;
   logic wr_fire;
   logic wr_hit;

   assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_reg <= 1'b0;
         awaddr_reg <= '0;
         s_axi_awready <= 1'b0;
      end else begin
         s_axi_awready <= !aw_held_reg && !(s_axi_awvalid && s_axi_awready);
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            awaddr_reg <= s_axi_awaddr;
         end else if (wr_fire) begin
            aw_held_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held_reg <= 1'b0;
         wdata_reg <= '0;
         wstrb_reg <= '0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_wready <= !w_held_reg && !(s_axi_wvalid && s_axi_wready);
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
         end else if (wr_fire) begin
            w_held_reg <= 1'b0;
         end
      end
   end

   always_comb begin
      wr_hit = (awaddr_reg == OFS_CTRL) || (awaddr_reg == OFS_LEN1) || (awaddr_reg == OFS_LEN2);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // settings; only byte lane 0 carries fields
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_reg <= CTRL_RESET;
         len1_reg <= LEN1_RESET;
         len2_reg <= LEN2_RESET;
      end else if (wr_fire && wstrb_reg[0]) begin
         case (awaddr_reg)
            OFS_CTRL: ctrl_reg <= wdata_reg[4:0];
            OFS_LEN1: len1_reg <= even_len(wdata_reg);
            OFS_LEN2: len2_reg <= even_len(wdata_reg);
            default: ctrl_reg <= ctrl_reg;
         endcase
      end
   end

   // axi read channel
   logic [31:0] rd_word;
   always_comb begin
      case (s_axi_araddr)
         OFS_CTRL: rd_word = {27'h0, ctrl_reg};
         OFS_LEN1: rd_word = {25'h0, len1_reg};
         OFS_LEN2: rd_word = {25'h0, len2_reg};
         OFS_STAT: rd_word = {21'h0, last_len_reg, 1'b0, last_cause_reg};
         OFS_ACC_CNT: rd_word = {16'h0, acc_cnt_reg};
         OFS_REJ_CNT: rd_word = {16'h0, rej_cnt_reg};
         default: rd_word = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= (s_axi_araddr <= OFS_REJ_CNT && s_axi_araddr[1:0] == 2'b00) ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // symbol collection
   itf_state_t state_reg;
   logic [LEN_W-1:0] count_reg;
   logic bad_reg;
   logic guard_ok_reg;
   logic chk_ok_reg;
   logic [LEN_W-1:0] send_idx_reg;
   logic [LEN_W-1:0] send_len_reg;
   logic [3:0] bar_digit;
   logic [3:0] space_digit;
   logic mem_we;
   logic [5:0] mem_waddr;
   logic [3:0] mem_wdata;
   logic [3:0] mem_rdata;
   logic pair_slot_reg;
   logic [3:0] space_hold_reg;
   logic rd_pending_reg;

   assign bar_digit = pattern_to_digit(pair_bar_pattern);
   assign space_digit = pattern_to_digit(pair_space_pattern);

   // each pair writes two cells: bar digit first, then the held space digit
   always_comb begin
      mem_we = 1'b0;
      mem_waddr = count_reg[5:0];
      mem_wdata = bar_digit;
      if (state_reg == ST_COLLECT && pair_slot_reg) begin
         mem_we = !count_reg[6];
         mem_wdata = space_hold_reg;
      end else if ((state_reg == ST_IDLE || state_reg == ST_COLLECT) && pair_valid && !pair_slot_reg) begin
         mem_we = !count_reg[6];
         mem_wdata = bar_digit;
      end
   end

   // length check over the collected digit count
   logic [LEN_W-1:0] lo_len;
   logic [LEN_W-1:0] hi_len;
   logic len_ok;
   always_comb begin
      lo_len = (len1_reg <= len2_reg) ? len1_reg : len2_reg;
      hi_len = (len1_reg <= len2_reg) ? len2_reg : len1_reg;
      if (ctrl_reg[CTRL_RANGE_BIT]) begin
         len_ok = (count_reg >= lo_len) && (count_reg <= hi_len);
      end else begin
         len_ok = (count_reg == len1_reg) || (count_reg == len2_reg);
      end
   end

   logic [2:0] cause;
   always_comb begin
      if (!ctrl_reg[CTRL_EN_BIT]) begin
         cause = REJ_DISABLED;
      end else if (bad_reg) begin
         cause = REJ_PATTERN;
      end else if (!len_ok) begin
         cause = REJ_LENGTH;
      end else if (ctrl_reg[CTRL_CHK_BIT] && !chk_ok_reg) begin
         cause = REJ_CHECK;
      end else if (ctrl_reg[CTRL_GUARD_BIT] && !guard_ok_reg) begin
         cause = REJ_GUARD;
      end else begin
         cause = REJ_NONE;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_reg <= ST_IDLE;
         count_reg <= '0;
         bad_reg <= 1'b0;
         guard_ok_reg <= 1'b0;
         chk_ok_reg <= 1'b0;
         pair_slot_reg <= 1'b0;
         space_hold_reg <= '0;
         send_idx_reg <= '0;
         send_len_reg <= '0;
         rd_pending_reg <= 1'b0;
         symbol_reject <= 1'b0;
         char_valid <= 1'b0;
         char_last <= 1'b0;
         char_data <= '0;
         last_cause_reg <= REJ_NONE;
         last_len_reg <= '0;
         acc_cnt_reg <= '0;
         rej_cnt_reg <= '0;
      end else begin
         symbol_reject <= 1'b0;
         char_valid <= 1'b0;
         char_last <= 1'b0;
         case (state_reg)
            ST_IDLE, ST_COLLECT: begin
               if (pair_slot_reg) begin
                  pair_slot_reg <= 1'b0;
                  count_reg <= count_reg + 7'd1;
                  if (rd_pending_reg) begin
                     rd_pending_reg <= 1'b0;
                     state_reg <= ST_VERDICT;
                  end
               end else if (pair_valid) begin
                  // one pair per two cycles; a pair arriving on the odd cycle is dropped
                  if (state_reg == ST_IDLE) begin
                     count_reg <= 7'd1;
                     bad_reg <= 1'b0;
                     guard_ok_reg <= is_guard(lead_guard_width, wide_bar_width);
                  end else begin
                     count_reg <= (count_reg[6]) ? count_reg : count_reg + 7'd1;
                  end
                  if (bar_digit == 4'hF || space_digit == 4'hF || count_reg[6]) begin
                     bad_reg <= 1'b1;
                  end
                  space_hold_reg <= space_digit;
                  pair_slot_reg <= 1'b1;
                  state_reg <= ST_COLLECT;
                  if (pair_last) begin
                     rd_pending_reg <= 1'b1;
                     chk_ok_reg <= check_pass;
                     guard_ok_reg <= ((state_reg == ST_IDLE) ? is_guard(lead_guard_width, wide_bar_width)
                        : guard_ok_reg) && is_guard(trail_guard_width, wide_bar_width);
                  end
               end
            end
            ST_VERDICT: begin
               last_len_reg <= count_reg;
               last_cause_reg <= cause;
               if (cause == REJ_NONE) begin
                  acc_cnt_reg <= acc_cnt_reg + 16'h0001;
                  send_idx_reg <= '0;
                  // the check digit is the last one of the symbol
                  send_len_reg <= (ctrl_reg[CTRL_CHKOUT_BIT] || count_reg == '0) ? count_reg
                     : count_reg - 7'd1;
                  state_reg <= ST_SEND;
               end else begin
                  rej_cnt_reg <= rej_cnt_reg + 16'h0001;
                  symbol_reject <= 1'b1;
                  count_reg <= '0;
                  state_reg <= ST_IDLE;
               end
            end
            ST_SEND: begin
               if (send_idx_reg == send_len_reg) begin
                  count_reg <= '0;
                  state_reg <= ST_IDLE;
               end else begin
                  send_idx_reg <= send_idx_reg + 7'd1;
               end
               if (send_idx_reg != '0) begin
                  char_valid <= 1'b1;
                  char_data <= mem_rdata;
                  char_last <= (send_idx_reg == send_len_reg);
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // read address leads char output by two cycles: the memory register, then the char output register
   logic [5:0] mem_raddr;
   always_comb begin
      mem_raddr = (state_reg == ST_SEND) ? send_idx_reg[5:0] : 6'h00;
   end

   itf_char_mem #(
      .DEPTH(64),
      .AW(6),
      .DW(4)
   ) u_mem (
      .aclk(aclk),
      .wr_en(mem_we),
      .wr_addr(mem_waddr),
      .wr_data(mem_wdata),
      .rd_addr(mem_raddr),
      .rd_data(mem_rdata)
   );
endmodule

// >>> rtl/itf_pkg.sv
// package: register map, field layout, reset values for the symbol validator
package itf_pkg;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned LEN_W = 7;
   localparam int unsigned CHAR_W = 4;
   localparam int unsigned WIDTH_W = 12;
   // register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_LEN1 = 8'h04;
   localparam logic [7:0] OFS_LEN2 = 8'h08;
   localparam logic [7:0] OFS_STAT = 8'h0C;
   localparam logic [7:0] OFS_ACC_CNT = 8'h10;
   localparam logic [7:0] OFS_REJ_CNT = 8'h14;
   // control field positions
   localparam int unsigned CTRL_EN_BIT = 0;
   localparam int unsigned CTRL_CHK_BIT = 1;
   localparam int unsigned CTRL_CHKOUT_BIT = 2;
   localparam int unsigned CTRL_GUARD_BIT = 3;
   localparam int unsigned CTRL_RANGE_BIT = 4;
   // reset values
   localparam logic [4:0] CTRL_RESET = 5'h10;
   localparam logic [6:0] LEN1_RESET = 7'h10;
   localparam logic [6:0] LEN2_RESET = 7'h06;
   localparam logic [6:0] LEN_MAX = 7'h40;
   // reject cause codes in the status register
   localparam logic [2:0] REJ_NONE = 3'h0;
   localparam logic [2:0] REJ_DISABLED = 3'h1;
   localparam logic [2:0] REJ_PATTERN = 3'h2;
   localparam logic [2:0] REJ_LENGTH = 3'h3;
   localparam logic [2:0] REJ_CHECK = 3'h4;
   localparam logic [2:0] REJ_GUARD = 3'h5;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_COLLECT = 2'b01,
      ST_VERDICT = 2'b10,
      ST_SEND = 2'b11
   } itf_state_t;
endpackage

// >>> rtl/itf_char_mem.sv
// symbol character store with registered read data
module itf_char_mem #(
   parameter int unsigned DEPTH = 64,
   parameter int unsigned AW = 6,
   parameter int unsigned DW = 4
) (
   input wire logic aclk,
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [DW-1:0] wr_data,
   input wire logic [AW-1:0] rd_addr,
   output logic [DW-1:0] rd_data
);
   logic [DW-1:0] mem [DEPTH];

   always_ff @(posedge aclk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge aclk) begin
      rd_data <= mem[rd_addr];
   end
endmodule

// >>> sim/itf_monitor.sv
// checker: port-level properties of the symbol validator
module itf_monitor
   import itf_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic pair_valid,
   input wire logic pair_last,
   input wire logic char_valid,
   input wire logic [itf_pkg::CHAR_W-1:0] char_data,
   input wire logic char_last,
   input wire logic symbol_reject,
   input wire logic s_axi_bvalid,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_rvalid
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [3:0] since_reg;
   logic [6:0] cnt_reg;
   // saturates so a stray output long after a symbol still fails
   always_ff @(posedge aclk) begin
      if (!aresetn)
         since_reg <= 4'hf;
      else if (pair_valid && pair_last)
         since_reg <= 4'h0;
      else if (since_reg != 4'hf)
         since_reg <= since_reg + 4'h1;
   end
   always_ff @(posedge aclk) begin
      if (!aresetn || (char_valid && char_last))
         cnt_reg <= 7'h00;
      else if (char_valid)
         cnt_reg <= cnt_reg + 7'h01;
   end
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_reset_quiet: assert property ($rose(aresetn) |-> !char_valid && !symbol_reject && !s_axi_bvalid
      && !s_axi_rvalid)
      else $error("output active after reset");
   a_reject_no_char: assert property (symbol_reject |-> !char_valid)
      else $error("digit sent with reject");
   a_reject_pulse: assert property (symbol_reject |=> !symbol_reject)
      else $error("reject longer than one cycle");
   a_last_with_valid: assert property (char_last |-> char_valid)
      else $error("last flag without digit");
   a_char_digit: assert property (char_valid |-> char_data <= 4'h9)
      else $error("digit above nine");
   a_stream_gapless: assert property (char_valid && !char_last |=> char_valid)
      else $error("gap inside digit stream");
   a_out_after_last: assert property ($rose(char_valid) |-> since_reg inside {[4'h2:4'h8]})
      else $error("digits without a recent symbol");
   a_reject_after_last: assert property (symbol_reject |-> since_reg inside {[4'h1:4'h8]})
      else $error("reject without a recent symbol");
   a_digit_cap: assert property (char_valid |-> cnt_reg < 7'h40)
      else $error("more than 64 digits");
   c_accept: cover property (char_valid && char_last);
   c_reject: cover property (symbol_reject);
   c_slverr: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule
bind itf_symbol_validator itf_monitor itf_monitor_i (.aclk, .aresetn, .pair_valid, .pair_last, .char_valid,
   .char_data, .char_last, .symbol_reject, .s_axi_bvalid, .s_axi_bresp, .s_axi_rvalid);

// >>> sim/itf_pair_src.sv
// upstream element decoder model: sends digit pairs from a queue
module itf_pair_src
   import itf_pkg::*;
(
   input wire logic aclk,
   output logic pair_valid,
   output logic [4:0] pair_bar_pattern,
   output logic [4:0] pair_space_pattern,
   output logic pair_last,
   output logic [itf_pkg::WIDTH_W-1:0] wide_bar_width,
   output logic [itf_pkg::WIDTH_W-1:0] lead_guard_width,
   output logic [itf_pkg::WIDTH_W-1:0] trail_guard_width,
   output logic check_pass
);
   timeunit 1ns;
   timeprecision 100ps;
   int q[$];
   function automatic logic [4:0] enc(input int d);
      logic [4:0] t[10] = '{5'h06, 5'h11, 5'h09, 5'h18, 5'h05, 5'h14, 5'h0c, 5'h03, 5'h12, 5'h0a};
      return t[d];
   endfunction
   initial begin
      pair_valid = 1'b0;
      pair_last = 1'b0;
      pair_bar_pattern = 5'h00;
      pair_space_pattern = 5'h00;
      wide_bar_width = 12'h030;
      lead_guard_width = 12'h060;
      trail_guard_width = 12'h060;
      check_pass = 1'b0;
   end
   // gap of one or more idle cycles keeps pairs at least two cycles apart
   task automatic send(input int gap, input bit gok, input bit cp);
      for (int i = 0; i < q.size(); i += 2) begin
         pair_valid <= 1'b1;
         pair_bar_pattern <= enc(q[i]);
         pair_space_pattern <= enc(q[i+1]);
         pair_last <= (i + 2 >= q.size());
         check_pass <= cp;
         lead_guard_width <= gok ? 12'h060 : 12'h05f;
         @(posedge aclk);
         pair_valid <= 1'b0;
         pair_last <= 1'b0;
         // stale patterns are inverted so nothing can reuse them
         pair_bar_pattern <= ~enc(q[i]);
         pair_space_pattern <= ~enc(q[i+1]);
         repeat (gap) @(posedge aclk);
      end
   endtask
endmodule

// >>> sim/testbench.sv
// self-checking bench for the symbol validator
`define CHK(nm, e, g) \
   begin \
      checked++; \
      if ((g) !== (e)) begin \
         miscompares++; \
         $display("wrong value %s expected %0h seen %0h", nm, e, g); \
      end \
   end
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   import itf_pkg::*;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, pair_valid, pair_last, check_pass;
   logic char_valid, char_last, symbol_reject;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb, char_data;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [4:0] pair_bar_pattern, pair_space_pattern;
   logic [11:0] wide_bar_width, lead_guard_width, trail_guard_width;
   int miscompares, checked, ctrl, l1, l2, n_acc, n_rej;
   logic [31:0] lfsr_st = 32'h544b_7fc7;
   int ln1[5] = '{4, 6, 10, 16, 18};
   int ln2[5] = '{2, 4, 12, 20, 22};
   int ln3[4] = '{8, 10, 12, 14};
   itf_symbol_validator itf_symbol_validator_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .pair_valid, .pair_bar_pattern, .pair_space_pattern, .pair_last, .wide_bar_width, .lead_guard_width,
      .trail_guard_width, .check_pass, .char_valid, .char_data, .char_last, .symbol_reject);
   itf_pair_src itf_pair_src_i (.aclk, .pair_valid, .pair_bar_pattern, .pair_space_pattern, .pair_last,
      .wide_bar_width, .lead_guard_width, .trail_guard_width, .check_pass);
   function automatic logic [31:0] lfsr();
      lfsr_st = {lfsr_st[30:0], ^(lfsr_st & 32'h8020_0003)};
      return lfsr_st;
   endfunction
   task automatic axw(input logic [7:0] a, input logic [7:0] v, output logic [1:0] r);
      bit aw_done, w_done;
      logic [31:0] rn;
      aw_done = 0;
      w_done = 0;
      rn = lfsr();
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= {rn[31:8], v};
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw_done && w_done)) begin
         @(posedge aclk);
         if (s_axi_awready === 1'b1 && !aw_done) begin
            aw_done = 1;
            s_axi_awvalid <= 1'b0;
         end
         if (s_axi_wready === 1'b1 && !w_done) begin
            w_done = 1;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
   endtask
   // only the low byte carries settings; upper bits are random noise
   task automatic reg_set(input logic [7:0] a, input int v);
      logic [1:0] r;
      logic [31:0] d;
      int e;
      axw(a, v[7:0], r);
      `CHK("write response", RESP_OKAY, r)
      e = (v > 64) ? 64 : (v & 32'hfe);
      if (a == OFS_CTRL)
         ctrl = v & 32'h1f;
      else if (a == OFS_LEN1)
         l1 = e;
      else
         l2 = e;
      axr(a, d, r);
      `CHK("read response", RESP_OKAY, r)
      `CHK("register", (a == OFS_CTRL) ? ctrl : e, d)
   endtask
   function automatic bit exp_ok(input int n, input bit gok, input bit cp);
      int lo, hi;
      lo = (l1 < l2) ? l1 : l2;
      hi = (l1 < l2) ? l2 : l1;
      if (!ctrl[0]) return 0;
      if (ctrl[4] && (n < lo || n > hi)) return 0;
      if (!ctrl[4] && n != l1 && n != l2) return 0;
      if (ctrl[1] && !cp) return 0;
      if (ctrl[3] && !gok) return 0;
      return 1;
   endfunction
   task automatic sym(input int n, input bit gok, input bit cp);
      int k, ec;
      bit ok;
      logic [31:0] rn;
      ok = exp_ok(n, gok, cp);
      if (ok)
         n_acc++;
      else
         n_rej++;
      ec = ok ? (ctrl[2] ? n : n - 1) : 0;
      itf_pair_src_i.q.delete();
      for (k = 0; k < n; k++) begin
         rn = lfsr();
         itf_pair_src_i.q.push_back(rn % 10);
      end
      itf_pair_src_i.send(1 + rn[0], gok, cp);
      k = 0;
      repeat (40) begin
         @(negedge aclk);
         if (char_valid === 1'b1 && k < n) begin
            `CHK("digit", itf_pair_src_i.q[k], char_data)
            `CHK("last flag", k == ec - 1, char_last)
            k++;
         end
         if (symbol_reject === 1'b1 || char_last === 1'b1) break;
      end
      `CHK("reject", !ok, symbol_reject)
      `CHK("digit count", ec, k)
      @(posedge aclk);
      @(posedge aclk);
   endtask
   task automatic complete_run();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end
   initial begin
      #5ms;
      miscompares++;
      complete_run();
   end
   initial begin
      logic [31:0] d;
      logic [1:0] r;
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0000_0000_0000;
      s_axi_wstrb = 4'hf;
      ctrl = 16;
      l1 = 16;
      l2 = 6;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      axr(OFS_CTRL, d, r);
      `CHK("control reset", 32'h0000_0010, d)
      axr(OFS_LEN1, d, r);
      `CHK("first length reset", 32'h0000_0010, d)
      axr(OFS_LEN2, d, r);
      `CHK("second length reset", 32'h0000_0006, d)
      axr(8'h18, d, r);
      `CHK("unmapped read", RESP_SLVERR, r)
      axw(8'h1c, 8'h01, r);
      `CHK("unmapped write", RESP_SLVERR, r)
      sym(6, 1'b1, 1'b1);
      reg_set(OFS_CTRL, 32'h11);
      foreach (ln1[i]) sym(ln1[i], 1'b1, 1'b1);
      reg_set(OFS_LEN1, 5);
      reg_set(OFS_LEN2, 65);
      reg_set(OFS_LEN2, 21);
      foreach (ln2[i]) sym(ln2[i], 1'b1, 1'b1);
      reg_set(OFS_CTRL, 32'h01);
      reg_set(OFS_LEN1, 8);
      reg_set(OFS_LEN2, 13);
      foreach (ln3[i]) sym(ln3[i], 1'b1, 1'b1);
      reg_set(OFS_CTRL, 32'h07);
      sym(8, 1'b1, 1'b0);
      sym(12, 1'b1, 1'b1);
      reg_set(OFS_CTRL, 32'h09);
      sym(8, 1'b0, 1'b1);
      sym(8, 1'b1, 1'b1);
      axr(OFS_ACC_CNT, d, r);
      `CHK("accept count", n_acc, d)
      axr(OFS_REJ_CNT, d, r);
      `CHK("reject count", n_rej, d)
      // last symbol: eight digits accepted, cause none
      axr(OFS_STAT, d, r);
      `CHK("status", 32'h0000_0080, d)
      complete_run();
   end
endmodule
